// ==== logic/failsafe_seq_pkg.sv ====
package failsafe_seq_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned INIT_WINDOW_MS  = 256;
    localparam int unsigned STUCK_RESET_MS  = 8000;
    localparam longint unsigned INIT_WINDOW_CYCLES = longint'(INIT_WINDOW_MS) * CLK_HZ / 1000;
    localparam longint unsigned STUCK_RESET_CYCLES = longint'(STUCK_RESET_MS) * CLK_HZ / 1000;

    // reset low duration choices, in microseconds (selected by init config reset_dur)
    localparam int unsigned RESET_LOW_US_0  = 10;
    localparam int unsigned RESET_LOW_US_1  = 1000;
    localparam int unsigned RESET_LOW_US_2  = 10000;
    localparam int unsigned RESET_LOW_US_3  = 100000;
    localparam int unsigned US_CYCLES       = CLK_HZ / 1_000_000;

    // fault error counter defaults
    localparam int unsigned FAULT_CNT_W     = 4;
    localparam logic [3:0]  FAULT_FINAL_DEF = 4'h6;

    // self-test duration in cycles
    localparam int unsigned SELF_TEST_CYCLES = 64;

    // option-select resistor code layout
    localparam int unsigned SEL_AUX_HI_POS   = 0;
    localparam int unsigned SEL_REF_HI_POS   = 1;
    localparam int unsigned SEL_DEEP_EN_POS  = 2;
    localparam int unsigned SEL_W            = 3;

    // reset values of init-only configuration
    localparam logic [1:0]  RESET_DUR_RST    = 2'h1;
    localparam logic        TIMER_OFF_RST    = 1'b0;
    localparam logic        AUX_CRIT_RST     = 1'b0;

    typedef enum {
        ST_OFF,
        ST_WAIT_PRE,
        ST_LOGIC_TEST,
        ST_SELECT,
        ST_ANALOG_TEST,
        ST_RELEASE,
        ST_INIT_PHASE,
        ST_PERIODIC,
        ST_RESET_LOW,
        ST_DEEP_SAFE,
        ST_DEEP_LOW_POWER_OFF
    } seq_state_t;

    // supervision thresholds and deep fail-safe enable selected by the option resistor
    typedef struct packed {
        logic aux_high;
        logic ref_high;
        logic deep_enable;
    } select_cfg_t;

    // init-only configuration presented by the mcu interface
    typedef struct packed {
        logic [1:0] reset_dur;
        logic       timer_off;
        logic       aux_critical;
        logic [3:0] fault_final;
    } init_cfg_t;

    // status back to the mcu interface
    typedef struct packed {
        logic       logic_test_fail;
        logic       analog_first_fail;
        logic       analog_second_fail;
        logic       analog_second_pass;
        logic       init_phase;
        logic       periodic;
        logic       deep_safe;
        logic [3:0] fault_count;
    } seq_status_t;

endpackage

// ==== logic/cycle_timer.sv ====
`timescale 1ns/100ps
// down-counter: load on start, done pulses once after it has counted down to one
module cycle_timer #(
    parameter int unsigned W = 32
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] load,
    // result
    output logic              running,
    output logic              done
);
    initial begin
        if (W < 2 || W > 40) $error("cycle_timer width out of range");
    end

    logic [W-1:0] count_reg;
    logic         run_reg;
    logic         done_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            run_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (stop) begin
                run_reg <= 1'b0;
            end else if (start) begin
                count_reg <= load;
                run_reg   <= 1'b1;
            end else if (run_reg) begin
                if (count_reg <= W'(1)) begin
                    run_reg  <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg - W'(1);
                end
            end
        end
    end

    assign running = run_reg;
    assign done    = done_reg;
endmodule // cycle_timer

// ==== logic/sync2.sv ====
`timescale 1ns/100ps
// two-flop synchroniser for a bus of independent levels
module sync2 #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    initial begin
        if (W < 1) $error("sync2 width must be positive");
    end

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule // sync2

// ==== logic/failsafe_state_sequencer.sv ====
// Functional notes
// R01: run logic self-test at every start-up and every low-power-off wake-up
// R02: logic test fail keeps safe outputs low, flags it, still releases mcu reset
// R03: option resistor sets aux/reference thresholds and deep fail-safe enable
// R04: analog test fail never blocks reset release, but blocks safe output release
// R05: always run first analog test at start-up and after wake-up
// R06: run second analog test only on mcu command
// R07: aux critical keeps first safe output low until second test passed
// R08: init phase follows both start-up tests and begins at reset release
// R09: init phase lasts at most 256 ms for configuration and first refresh
// R10: init-only configuration writable only during init phase, then locked
// R11: first good refresh ends init phase at once, periodic supervision follows
// R12: window period configurable in init phase and periodic supervision
// R13: leave periodic supervision on any reset fault, external request included
// R14: after reset low, delay then release only if no fault remains
// R15: reset low duration comes from init-only configuration
// R16: safe output handling and second test run beside init and periodic states
// R17: deep fail-safe on final fault count or reset low beyond 8.0 s
// R18: deep fail-safe: regulators off except keep-alive, all safe outputs low
// R19: deep fail-safe left only by key low then key high
// R20: stuck-reset timer runs from wait-pre-supply state until reset release
// R21: timer disable bit in init phase; periodic restarts timer each reset
// R22: mcu reset and both safe outputs are active low
// R23: bad or missing first refresh asserts reset and first safe output, count+1
// R24: fault counter increments by one per reset or first safe output assertion
// R25: safe outputs held low from power-on until all needed tests pass
`timescale 1ns/100ps
module failsafe_state_sequencer #(
    parameter longint unsigned INIT_WINDOW  = failsafe_seq_pkg::INIT_WINDOW_CYCLES,
    parameter longint unsigned STUCK_RESET  = failsafe_seq_pkg::STUCK_RESET_CYCLES,
    parameter int unsigned     TEST_CYCLES  = failsafe_seq_pkg::SELF_TEST_CYCLES
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // power and analog events (asynchronous levels)
    input  wire logic                          pre_supply_ok,
    input  wire logic                          logic_test_ok,
    input  wire logic                          analog_first_ok,
    input  wire logic                          analog_second_ok,
    input  wire logic [2:0]                    select_code,
    input  wire logic                          fault_present,
    input  wire logic                          ext_reset_req,
    input  wire logic                          key_on,
    input  wire logic                          wake_event,
    // mcu side requests (same clock domain, one-cycle pulses)
    input  wire logic                          refresh_good,
    input  wire logic                          refresh_bad,
    input  wire logic                          analog_second_req,
    input  wire logic                          cfg_write,
    input  wire failsafe_seq_pkg::init_cfg_t   cfg_wdata,
    input  wire logic                          window_write,
    input  wire logic [3:0]                    window_wdata,
    // pins
    output logic                               mcu_reset_n,
    output logic                               safe_out_first_n,
    output logic                               safe_out_second_n,
    output logic                               regulators_on,
    output logic                               keep_alive_on,
    // configuration and status
    output failsafe_seq_pkg::select_cfg_t      select_cfg,
    output failsafe_seq_pkg::init_cfg_t        init_cfg,
    output logic [3:0]                         window_cfg,
    output logic                               logic_test_run,
    output logic                               analog_first_run,
    output logic                               analog_second_run,
    output failsafe_seq_pkg::seq_status_t      status
);
    initial begin
        if (INIT_WINDOW < 2 || INIT_WINDOW > 40'hFF_FFFF_FFFF) $error("bad init window");
        if (STUCK_RESET < 2 || STUCK_RESET > 40'hFF_FFFF_FFFF) $error("bad stuck reset");
        if (TEST_CYCLES < 2) $error("bad test length");
    end

    localparam int unsigned TW = 40;

    // synchronised asynchronous inputs
    logic [11:0] async_in;
    logic [11:0] async_s;
    assign async_in = {pre_supply_ok, logic_test_ok, analog_first_ok, analog_second_ok,
                       select_code, fault_present, ext_reset_req, key_on, wake_event, 1'b0};
    sync2 #(.W(12)) u_sync (.clk(clk), .rst_n(rst_n), .d(async_in), .q(async_s));

    logic       pre_ok_s;
    logic       lt_ok_s;
    logic       a1_ok_s;
    logic       a2_ok_s;
    logic [2:0] sel_s;
    logic       fault_s;
    logic       ext_rst_s;
    logic       key_s;
    logic       wake_s;
    assign pre_ok_s  = async_s[11];
    assign lt_ok_s   = async_s[10];
    assign a1_ok_s   = async_s[9];
    assign a2_ok_s   = async_s[8];
    assign sel_s     = async_s[7:5];
    assign fault_s   = async_s[4];
    assign ext_rst_s = async_s[3];
    assign key_s     = async_s[2];
    assign wake_s    = async_s[1];

    failsafe_seq_pkg::seq_state_t state_reg;
    failsafe_seq_pkg::seq_state_t state_next;

    logic [15:0] step_reg;
    logic        lt_fail_reg;
    logic        a1_fail_reg;
    logic        a2_fail_reg;
    logic        a2_pass_reg;
    logic        a2_busy_reg;
    logic [3:0]  fault_cnt_reg;
    logic        key_prev_reg;
    logic        rst_out_reg;
    logic        fs0_reg;
    logic        fs1_reg;
    logic        reg_on_reg;
    logic        kam_reg;
    failsafe_seq_pkg::select_cfg_t sel_reg;
    failsafe_seq_pkg::init_cfg_t   cfg_reg;
    logic [3:0]  window_reg;
    failsafe_seq_pkg::seq_status_t status_reg;

    logic in_init;
    logic in_periodic;
    logic test_done;
    logic init_to;
    logic stuck_to;
    logic stuck_run;
    logic reset_fault;
    logic enter_reset;
    logic rlow_run;
    logic [TW-1:0] rlow_load;

    assign in_init     = (state_reg == failsafe_seq_pkg::ST_INIT_PHASE);
    assign in_periodic = (state_reg == failsafe_seq_pkg::ST_PERIODIC);
    assign test_done   = (step_reg == 16'(TEST_CYCLES - 1));
    // R13 reset faults
    assign reset_fault = fault_s | ext_rst_s;
    // R23 missing or bad first refresh
    assign enter_reset = (in_init & (init_to | refresh_bad | reset_fault))
                       | (in_periodic & reset_fault);

    always_comb begin
        case (cfg_reg.reset_dur)
            2'h0:    rlow_load = TW'(failsafe_seq_pkg::RESET_LOW_US_0 * failsafe_seq_pkg::US_CYCLES);
            2'h1:    rlow_load = TW'(failsafe_seq_pkg::RESET_LOW_US_1 * failsafe_seq_pkg::US_CYCLES);
            2'h2:    rlow_load = TW'(failsafe_seq_pkg::RESET_LOW_US_2 * failsafe_seq_pkg::US_CYCLES);
            default: rlow_load = TW'(failsafe_seq_pkg::RESET_LOW_US_3 * failsafe_seq_pkg::US_CYCLES);
        endcase
    end

    // R09 init window limit
    cycle_timer #(.W(TW)) u_init_timer (
        .clk(clk), .rst_n(rst_n),
        .start(state_reg == failsafe_seq_pkg::ST_RELEASE),
        .stop(!in_init && state_reg != failsafe_seq_pkg::ST_RELEASE),
        .load(TW'(INIT_WINDOW)), .running(), .done(init_to));

    // R14 reset low delay
    logic rlow_start;
    assign rlow_start = enter_reset;
    cycle_timer #(.W(TW)) u_rlow_timer (
        .clk(clk), .rst_n(rst_n),
        .start(rlow_start), .stop(1'b0),
        .load(rlow_load), .running(rlow_run), .done());

    // R20 R21 stuck reset timer: start at wait-pre, or at reset entry unless disabled; stop at release or deep fail-safe
    logic stuck_start;
    logic stuck_stop;
    assign stuck_start = (state_reg == failsafe_seq_pkg::ST_OFF)
                       | (enter_reset & in_periodic & !cfg_reg.timer_off)
                       | (enter_reset & in_init & !cfg_reg.timer_off);
    assign stuck_stop  = (state_reg == failsafe_seq_pkg::ST_RELEASE)
                       | (state_reg == failsafe_seq_pkg::ST_RESET_LOW && state_next == failsafe_seq_pkg::ST_PERIODIC)
                       | (state_reg == failsafe_seq_pkg::ST_DEEP_SAFE);
    cycle_timer #(.W(TW)) u_stuck_timer (
        .clk(clk), .rst_n(rst_n),
        .start(stuck_start), .stop(stuck_stop),
        .load(TW'(STUCK_RESET)), .running(stuck_run), .done(stuck_to));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            failsafe_seq_pkg::ST_OFF:         state_next = failsafe_seq_pkg::ST_WAIT_PRE;
            failsafe_seq_pkg::ST_WAIT_PRE:    if (pre_ok_s) state_next = failsafe_seq_pkg::ST_LOGIC_TEST;
            // R01 logic test every start
            failsafe_seq_pkg::ST_LOGIC_TEST:  if (test_done) state_next = failsafe_seq_pkg::ST_SELECT;
            failsafe_seq_pkg::ST_SELECT:      state_next = failsafe_seq_pkg::ST_ANALOG_TEST;
            // R05 first analog test every start
            failsafe_seq_pkg::ST_ANALOG_TEST: if (test_done) state_next = failsafe_seq_pkg::ST_RELEASE;
            // R08 init starts at reset release
            failsafe_seq_pkg::ST_RELEASE:     state_next = failsafe_seq_pkg::ST_INIT_PHASE;
            failsafe_seq_pkg::ST_INIT_PHASE: begin
                // R11 leave init on good refresh
                if (enter_reset) state_next = failsafe_seq_pkg::ST_RESET_LOW;
                else if (refresh_good) state_next = failsafe_seq_pkg::ST_PERIODIC;
            end
            failsafe_seq_pkg::ST_PERIODIC:    if (enter_reset) state_next = failsafe_seq_pkg::ST_RESET_LOW;
            failsafe_seq_pkg::ST_RESET_LOW:   if (!rlow_run && !reset_fault) state_next = failsafe_seq_pkg::ST_PERIODIC;
            // R19 key off then key on
            failsafe_seq_pkg::ST_DEEP_SAFE:   if (!key_s) state_next = failsafe_seq_pkg::ST_DEEP_LOW_POWER_OFF;
            failsafe_seq_pkg::ST_DEEP_LOW_POWER_OFF:  if (key_s && !key_prev_reg) state_next = failsafe_seq_pkg::ST_OFF;
            default:                          state_next = failsafe_seq_pkg::ST_OFF;
        endcase
        // R17 deep fail-safe entry
        if (sel_reg.deep_enable && state_reg != failsafe_seq_pkg::ST_DEEP_SAFE
            && state_reg != failsafe_seq_pkg::ST_DEEP_LOW_POWER_OFF
            && (fault_cnt_reg >= cfg_reg.fault_final || stuck_to))
            state_next = failsafe_seq_pkg::ST_DEEP_SAFE;
        // wake event while pre-supply is not ok keeps the sequencer in wait-pre
        if (wake_s && state_reg == failsafe_seq_pkg::ST_WAIT_PRE && !pre_ok_s)
            state_next = failsafe_seq_pkg::ST_WAIT_PRE;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= failsafe_seq_pkg::ST_OFF;
            step_reg     <= '0;
            key_prev_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            key_prev_reg <= key_s;
            step_reg     <= (state_next != state_reg) ? '0 : step_reg + 16'h0001;
        end
    end

    // self-test results, reset at each new start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lt_fail_reg <= 1'b0;
            a1_fail_reg <= 1'b0;
            sel_reg     <= '0;
        end else begin
            if (state_reg == failsafe_seq_pkg::ST_WAIT_PRE) begin
                lt_fail_reg <= 1'b0;
                a1_fail_reg <= 1'b0;
            end
            // R02 logic fail flag
            if (state_reg == failsafe_seq_pkg::ST_LOGIC_TEST && test_done) lt_fail_reg <= !lt_ok_s;
            // R03 option resistor capture
            if (state_reg == failsafe_seq_pkg::ST_SELECT) begin
                sel_reg.aux_high    <= sel_s[failsafe_seq_pkg::SEL_AUX_HI_POS];
                sel_reg.ref_high    <= sel_s[failsafe_seq_pkg::SEL_REF_HI_POS];
                sel_reg.deep_enable <= sel_s[failsafe_seq_pkg::SEL_DEEP_EN_POS];
            end
            if (state_reg == failsafe_seq_pkg::ST_ANALOG_TEST && test_done) a1_fail_reg <= !a1_ok_s;
        end
    end

    // R06 R16 second analog test beside init and periodic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a2_busy_reg <= 1'b0;
            a2_pass_reg <= 1'b0;
            a2_fail_reg <= 1'b0;
        end else if (state_reg == failsafe_seq_pkg::ST_WAIT_PRE) begin
            a2_busy_reg <= 1'b0;
            a2_pass_reg <= 1'b0;
            a2_fail_reg <= 1'b0;
        end else if (a2_busy_reg) begin
            a2_busy_reg <= 1'b0;
            a2_pass_reg <= a2_ok_s;
            a2_fail_reg <= !a2_ok_s;
        end else if (analog_second_req && (in_init || in_periodic)) begin
            a2_busy_reg <= 1'b1;
        end
    end

    // R10 R15 init-only lock; R12 window always writable in init and periodic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg.reset_dur    <= failsafe_seq_pkg::RESET_DUR_RST;
            cfg_reg.timer_off    <= failsafe_seq_pkg::TIMER_OFF_RST;
            cfg_reg.aux_critical <= failsafe_seq_pkg::AUX_CRIT_RST;
            cfg_reg.fault_final  <= failsafe_seq_pkg::FAULT_FINAL_DEF;
            window_reg           <= 4'h2;
        end else begin
            if (cfg_write && in_init) cfg_reg <= cfg_wdata;
            if (window_write && (in_init || in_periodic)) window_reg <= window_wdata;
        end
    end

    // R24 fault counter, one per assertion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_cnt_reg <= '0;
        end else if (state_reg == failsafe_seq_pkg::ST_DEEP_LOW_POWER_OFF) begin
            fault_cnt_reg <= '0;
        end else if (enter_reset && fault_cnt_reg != 4'hF) begin
            fault_cnt_reg <= fault_cnt_reg + 4'h1;
        end
    end

    // R22 R25 R02 R04 R07 R18 pins
    logic release_ok;
    assign release_ok = !lt_fail_reg && !a1_fail_reg && !fault_s
                      && (!cfg_reg.aux_critical || a2_pass_reg);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_out_reg <= 1'b0;
            fs0_reg     <= 1'b0;
            fs1_reg     <= 1'b0;
            reg_on_reg  <= 1'b0;
            kam_reg     <= 1'b0;
        end else begin
            rst_out_reg <= (state_next == failsafe_seq_pkg::ST_INIT_PHASE)
                        || (state_next == failsafe_seq_pkg::ST_PERIODIC);
            if (state_next == failsafe_seq_pkg::ST_DEEP_SAFE || state_next == failsafe_seq_pkg::ST_DEEP_LOW_POWER_OFF
                || state_next == failsafe_seq_pkg::ST_WAIT_PRE || enter_reset) begin
                fs0_reg <= 1'b0;
                fs1_reg <= 1'b0;
            end else if (in_periodic && release_ok) begin
                fs0_reg <= 1'b1;
                fs1_reg <= a2_pass_reg;
            end
            reg_on_reg <= state_next != failsafe_seq_pkg::ST_DEEP_SAFE
                       && state_next != failsafe_seq_pkg::ST_DEEP_LOW_POWER_OFF
                       && state_next != failsafe_seq_pkg::ST_OFF;
            if (state_reg == failsafe_seq_pkg::ST_WAIT_PRE) kam_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= '0;
        end else begin
            status_reg.logic_test_fail    <= lt_fail_reg;
            status_reg.analog_first_fail  <= a1_fail_reg;
            status_reg.analog_second_fail <= a2_fail_reg;
            status_reg.analog_second_pass <= a2_pass_reg;
            status_reg.init_phase         <= in_init;
            status_reg.periodic           <= in_periodic;
            status_reg.deep_safe          <= state_reg == failsafe_seq_pkg::ST_DEEP_SAFE;
            status_reg.fault_count        <= fault_cnt_reg;
        end
    end

    logic lt_run_reg;
    logic a1_run_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lt_run_reg <= 1'b0;
            a1_run_reg <= 1'b0;
        end else begin
            lt_run_reg <= state_next == failsafe_seq_pkg::ST_LOGIC_TEST;
            a1_run_reg <= state_next == failsafe_seq_pkg::ST_ANALOG_TEST;
        end
    end

    assign mcu_reset_n       = rst_out_reg;
    assign safe_out_first_n  = fs0_reg;
    assign safe_out_second_n = fs1_reg;
    assign regulators_on     = reg_on_reg;
    assign keep_alive_on     = kam_reg;
    assign select_cfg        = sel_reg;
    assign init_cfg          = cfg_reg;
    assign window_cfg        = window_reg;
    assign logic_test_run    = lt_run_reg;
    assign analog_first_run  = a1_run_reg;
    assign analog_second_run = a2_busy_reg;
    assign status            = status_reg;
endmodule // failsafe_state_sequencer

// ==== dv/mcu_model.sv ====
`timescale 1ns/100ps
module mcu_model (
    // clock and pins
    input  wire logic clk,
    input  wire logic mcu_reset_n,
    input  wire logic live,
    // requests
    output logic      refresh_good,
    output logic      analog_second_req
);
    int n = 0;
    // second test, then first refresh well inside the window
    always @(posedge clk) begin
        n <= mcu_reset_n ? n + 1 : 0;
        analog_second_req <= #2 live && n == 20;
        refresh_good <= #2 live && n == 60;
    end
endmodule // mcu_model

// ==== dv/failsafe_state_sequencer_chk.sv ====
`timescale 1ns/100ps
module failsafe_state_sequencer_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched
    input wire logic refresh_good,
    input wire logic cfg_write,
    input wire logic mcu_reset_n,
    input wire logic safe_out_first_n,
    input wire logic safe_out_second_n,
    input wire logic regulators_on,
    input wire failsafe_seq_pkg::init_cfg_t   init_cfg,
    input wire failsafe_seq_pkg::seq_status_t status
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_holds_safe: assert property (!mcu_reset_n |-> !safe_out_first_n && !safe_out_second_n)
        else $error("safe output high in reset");
    a_logic_fail_safe: assert property (status.logic_test_fail |-> !safe_out_first_n && !safe_out_second_n)
        else $error("safe output high after logic fail");
    a_analog_fail_safe: assert property (status.analog_first_fail |-> !safe_out_first_n)
        else $error("safe output high after analog fail");
    a_second_gate: assert property (safe_out_second_n |-> status.analog_second_pass)
        else $error("second output released untested");
    a_aux_gate: assert property (init_cfg.aux_critical && !status.analog_second_pass |-> !safe_out_first_n)
        else $error("first output released untested");
    a_deep_off: assert property (status.deep_safe [*2] |-> !regulators_on && !mcu_reset_n)
        else $error("deep state outputs wrong");
    a_cfg_locked: assert property (cfg_write && !status.init_phase ##1 !status.init_phase
        |-> $stable(init_cfg))
        else $error("config written outside init");
    a_first_refresh: assert property (refresh_good && status.init_phase |-> ##[1:2] status.periodic)
        else $error("no periodic after refresh");
    a_fault_step: assert property ($fell(mcu_reset_n) && status.fault_count != 4'hF ##1 !status.deep_safe
        |-> status.fault_count == $past(status.fault_count, 2) + 4'h1)
        else $error("fault count step wrong");
    cover property ($rose(status.periodic));
    cover property ($rose(status.deep_safe));
    cover property ($rose(safe_out_second_n));
endmodule // failsafe_state_sequencer_chk
bind failsafe_state_sequencer failsafe_state_sequencer_chk u_chk (.clk, .rst_n, .refresh_good, .cfg_write,
    .mcu_reset_n, .safe_out_first_n, .safe_out_second_n, .regulators_on, .init_cfg, .status);

// ==== dv/failsafe_state_sequencer_tb.sv ====
`timescale 1ns/100ps
`define CHK(s, e, a) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %0h got %0h", s, e, a); end end
`define WAITC(c, k) for (int i = 0; i < k && !(c); i++) step(1);
module failsafe_state_sequencer_tb;
    logic clk = 0, rst_n = 0, pre = 0, lt_ok = 1, a1_ok = 1, ext = 0, key = 1, live = 1, cw = 0, ww = 0;
    logic rg, a2r, mr_n, s1_n, s2_n, reg_on, kam, ltr, a1r, a2run, flt = 0, rb = 0;
    logic [2:0] sel = 3'h6;
    logic [3:0] wd = 4'h0, wc;
    failsafe_seq_pkg::init_cfg_t   cd = '0, ic;
    failsafe_seq_pkg::select_cfg_t sc;
    failsafe_seq_pkg::seq_status_t st;
    int n_fail = 0, tests_run = 0, cyc = 0, n_a2 = 0;
    failsafe_state_sequencer #(.INIT_WINDOW(200), .STUCK_RESET(2000), .TEST_CYCLES(4)) u_failsafe_state_sequencer (
        .clk, .rst_n, .pre_supply_ok(pre), .logic_test_ok(lt_ok), .analog_first_ok(a1_ok), .analog_second_ok(1'b1),
        .select_code(sel), .fault_present(flt), .ext_reset_req(ext), .key_on(key), .wake_event(1'b0),
        .refresh_good(rg), .refresh_bad(rb), .analog_second_req(a2r), .cfg_write(cw), .cfg_wdata(cd),
        .window_write(ww), .window_wdata(wd), .mcu_reset_n(mr_n), .safe_out_first_n(s1_n), .safe_out_second_n(s2_n),
        .regulators_on(reg_on), .keep_alive_on(kam), .select_cfg(sc), .init_cfg(ic), .window_cfg(wc),
        .logic_test_run(ltr), .analog_first_run(a1r), .analog_second_run(a2run), .status(st));
    mcu_model u_mcu_model (.clk, .mcu_reset_n(mr_n), .live, .refresh_good(rg), .analog_second_req(a2r));
    initial forever #12.5 clk = ~clk;
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict;
        end
    end
    always @(posedge clk) if (a2run === 1'b1) n_a2++;
    task automatic step(int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    // one pulse: c high writes init config, low writes the window
    task automatic wr(logic c, logic [7:0] v);
        cw = c;
        ww = !c;
        cd = v;
        wd = v[3:0];
        step(1);
        cw = 0;
        ww = 0;
    endtask
    initial begin
        step(6);
        rst_n = 1;
        pre = 1;
        `WAITC(st.init_phase, 100)
        `CHK("release", 1'b1, mr_n)
        `CHK("select", 3'h3, sc)
        wr(1, 8'h12);
        wr(0, 8'h0A);
        `CHK("cfg", 8'h12, ic)
        `CHK("window", 4'hA, wc)
        `WAITC(st.periodic, 100)
        step(3);
        `CHK("safe", 2'h3, {s1_n, s2_n})
        `CHK("a2run", 1, n_a2)
        wr(1, 8'h00);
        wr(0, 8'h05);
        `CHK("locked", 8'h12, ic)
        `CHK("window2", 4'h5, wc)
        live = 0;
        ext = 1;
        step(5);
        `CHK("ext", 1'b0, mr_n)
        `CHK("count1", 4'h1, st.fault_count)
        step(300);
        `CHK("held", 1'b0, mr_n)
        step(150);
        `CHK("fault", 1'b0, mr_n)
        ext = 0;
        `WAITC(mr_n, 20)
        `CHK("rel", 1'b1, mr_n)
        flt = 1;
        step(5);
        `CHK("count2", 4'h2, st.fault_count)
        `WAITC(st.deep_safe, 50)
        step(2);
        `CHK("deep", 4'h8, {st.deep_safe, reg_on, mr_n, s2_n})
        `CHK("kam", 1'b1, kam)
        lt_ok = 0;
        a1_ok = 0;
        flt = 0;
        key = 0;
        step(20);
        key = 1;
        `WAITC(ltr, 50)
        `CHK("retest", 1'b1, ltr)
        `WAITC(a1r, 50)
        `CHK("analog", 1'b1, a1r)
        `WAITC(mr_n, 100)
        `CHK("diag", 4'hE, {mr_n, st.logic_test_fail, st.analog_first_fail, s1_n})
        rb = 1;
        step(1);
        rb = 0;
        step(2);
        `CHK("bad", 5'h02, {st.fault_count, mr_n})
        give_verdict;
    end
endmodule // failsafe_state_sequencer_tb
